// ==== src/rdfp_cfg.svh ====
// Operation
// - two independent 64-byte FIFOs, receive and transmit
// - host reaches both FIFOs only over SPI
// - detect receive overflow and transmit underflow
// - header status byte carries selected FIFO fill
// - both byte counts visible as status fields
// - receive push with last-byte read duplicates that byte
// - 4-bit field selects shared threshold point
// - rx threshold 4(N+1), tx threshold 61-4N
// - threshold flag high when count reaches threshold
// - pin select 0x00 rx, 0x02 tx threshold
`ifndef RDFP_CFG_SVH
`define RDFP_CFG_SVH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define RDFP_DATA_W 8
`define RDFP_FIFO_DEPTH 64
`define RDFP_STAGE_DEPTH 8
`define RDFP_COUNT_W 7
`define RDFP_THR_W 4
`define RDFP_SEL_W 6

// ----------------------------------------------------------------------
// threshold coding
// ----------------------------------------------------------------------
`define RDFP_RX_THR_STEP 7'h04
`define RDFP_TX_THR_BASE 7'h3d

// ----------------------------------------------------------------------
// output pin selection codes
// ----------------------------------------------------------------------
`define RDFP_SEL_RX_THR 6'h00
`define RDFP_SEL_TX_THR 6'h02

// ----------------------------------------------------------------------
// spi framing
// ----------------------------------------------------------------------
`define RDFP_LAST_BIT 3'h7
`define RDFP_CS_IDLE 1'b1

`endif

// ==== src/rdfp_pkg.sv ====
`include "rdfp_cfg.svh"

package rdfp_pkg;

  // ----------------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------------
  typedef logic [`RDFP_DATA_W-1:0] rdfp_byte_t;
  typedef logic [`RDFP_COUNT_W-1:0] rdfp_count_t;
  typedef logic [`RDFP_THR_W-1:0] rdfp_thr_t;
  typedef logic [`RDFP_SEL_W-1:0] rdfp_sel_t;

  // spi access phase
  typedef enum logic [1:0]
  {
    PH_IDLE = 2'b00,
    PH_HEADER = 2'b01,
    PH_DATA = 2'b10
  } rdfp_phase_e;

endpackage

// ==== src/rdfp_mem.sv ====
`timescale 1ns/10ps

module rdfp_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port, data one cycle later
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] store [DEPTH]; // no reset, contents are don't-care
  logic bypass; // write and read hit the same word

  assign bypass = we && (waddr == raddr);

  // array write
  always_ff @(posedge clk)
  begin
    if (we)
      store[waddr] <= wdata;
  end

  // registered read; bypass so a byte pushed into an empty fifo shows at once
  always_ff @(posedge clk)
  begin
    if (!rstn)
      rdata_q <= '0;
    else
      rdata_q <= bypass ? wdata : store[raddr];
  end

endmodule

// ==== src/rdfp_fifo.sv ====
`timescale 1ns/10ps

module rdfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int DUP_HAZARD = 0,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // level
  output logic [CW-1:0] fillCount
);

  // ----------------------------------------------------------------------
  // pointers and count
  // ----------------------------------------------------------------------
  logic [AW-1:0] wrPtr_q, wrPtr_d; // next slot to write
  logic [AW-1:0] rdPtr_q, rdPtr_d; // head slot
  logic [CW-1:0] count_q, count_d; // bytes held
  logic doPush; // accepted write
  logic doPop; // accepted read
  logic stall; // read pointer misses its step
  logic advance; // read pointer really moves

  assign inReady = count_q != CW'(DEPTH);
  assign outValid = count_q != '0;
  assign doPush = inValid && inReady;
  assign doPop = outReady && outValid;
  // only the receive instance reproduces the pointer slip
  assign stall = (DUP_HAZARD != 0) && doPush && doPop && (count_q == CW'(1));
  assign advance = doPop && !stall;
  assign wrPtr_d = flush ? '0 : (doPush ? wrPtr_q + AW'(1) : wrPtr_q);
  assign rdPtr_d = flush ? '0 : (advance ? rdPtr_q + AW'(1) : rdPtr_q);
  assign count_d = flush ? '0 : count_q + CW'(doPush) - CW'(advance);
  assign fillCount = count_q;

  // pointer registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------------
  // storage; a write while full lands on the head slot and corrupts it
  // ----------------------------------------------------------------------
  rdfp_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .rstn(rstn),
    .we(inValid),
    .waddr(wrPtr_q),
    .wdata(inData),
    .raddr(rdPtr_d),
    .rdata_q(outData)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_pop_step;
    @(posedge clk) disable iff (!rstn)
    (doPop && !doPush && !flush) |=> (count_q == $past(count_q) - CW'(1));
  endproperty
  a_pop_step: assert property (p_pop_step) else $error("pop did not lower count");

  property p_dup_byte;
    @(posedge clk) disable iff (!rstn)
    (stall && !flush) |=> (count_q == CW'(2)) && (outData == $past(outData));
  endproperty
  a_dup_byte: assert property (p_dup_byte) else $error("last byte not repeated");

  c_dup_byte: cover property (@(posedge clk) disable iff (!rstn) stall);

endmodule

// ==== src/rdfp_top.sv ====
`timescale 1ns/10ps
`include "rdfp_cfg.svh"

module rdfp_top
  import rdfp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // spi pins from the host
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // modem receive stream
  input wire logic modemRxValid,
  output logic modemRxReady,
  input wire rdfp_byte_t modemRxData,
  // modem transmit stream
  input wire logic modemTxPop,
  output logic modemTxValid,
  output rdfp_byte_t modemTxData,
  // control
  input wire logic rxFlush,
  input wire logic txFlush,
  input wire rdfp_thr_t thresholdConfig,
  input wire rdfp_sel_t outputPinSelect,
  // status
  output rdfp_count_t rxCountStatus,
  output rdfp_count_t txCountStatus,
  output logic rxOverflow,
  output logic txUnderflow,
  output logic generalOutputPin
);

  // ----------------------------------------------------------------------
  // threshold arithmetic
  // ----------------------------------------------------------------------
  // receive threshold counts up in steps of four from four
  function automatic rdfp_count_t rxThreshold(input rdfp_thr_t n);
    return {1'b0, n, 2'b00} + `RDFP_RX_THR_STEP;
  endfunction

  // transmit threshold is coded the other way round
  function automatic rdfp_count_t txThreshold(input rdfp_thr_t n);
    return `RDFP_TX_THR_BASE - {1'b0, n, 2'b00};
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic csS1_q, csS2_q; // chip select, two stages
  logic sclkS1_q, sclkS2_q, sclkS3_q; // serial clock, third stage for edges
  logic mosiS1_q, mosiS2_q; // serial data in

  // the host clock is slow against clk, so sampling finds every edge
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      csS1_q <= `RDFP_CS_IDLE;
      csS2_q <= `RDFP_CS_IDLE;
      sclkS1_q <= 1'b0;
      sclkS2_q <= 1'b0;
      sclkS3_q <= 1'b0;
      mosiS1_q <= 1'b0;
      mosiS2_q <= 1'b0;
    end
    else
    begin
      csS1_q <= spiCsN;
      csS2_q <= csS1_q;
      sclkS1_q <= spiSclk;
      sclkS2_q <= sclkS1_q;
      sclkS3_q <= sclkS2_q;
      mosiS1_q <= spiMosi;
      mosiS2_q <= mosiS1_q;
    end
  end

  // ----------------------------------------------------------------------
  // fifo wiring
  // ----------------------------------------------------------------------
  logic stageValid; // staging buffer holds a byte
  logic stageReady; // staging buffer has room
  rdfp_byte_t stageData; // head of staging buffer
  logic rxInReady; // receive fifo has room
  logic rxOutValid; // receive fifo not empty
  rdfp_byte_t rxOutData; // head of receive fifo
  logic stageMove; // byte moves from staging to receive fifo
  logic rxPopReq; // pop on the byte's first bit, so a frame cut inside a byte loses that byte
  logic txPushReq; // host write stores one byte
  rdfp_byte_t txPushData; // byte completed by the host
  logic txInReady; // transmit fifo has room, host ignores it
  logic ovfEvent; // modem byte lost
  logic unfEvent; // modem pulled from empty fifo

  assign stageMove = stageValid && rxInReady;
  assign modemRxReady = stageReady;
  assign ovfEvent = modemRxValid && !stageReady;
  assign unfEvent = modemTxPop && !modemTxValid;

  // ----------------------------------------------------------------------
  // spi access engine
  // ----------------------------------------------------------------------
  rdfp_phase_e phase_q, phase_d; // where in the access we are
  logic [2:0] bitCnt_q, bitCnt_d; // bit within current byte
  logic isRead_q, isRead_d; // access direction from header msb
  rdfp_byte_t shiftIn_q, shiftIn_d; // bits from mosi
  rdfp_byte_t shiftOut_q, shiftOut_d; // bits to miso, msb first
  logic loadPending_q, loadPending_d; // fetch a fifo byte at next fall
  logic csActive; // chip selected after sync
  logic sclkRise; // device samples mosi here
  logic sclkFall; // miso changes here
  logic byteDone; // eighth rising edge of a byte
  logic firstBit; // rising edge carrying the direction bit
  logic errFlag; // any sticky fault
  rdfp_count_t fillSel; // fill level chosen by direction

  assign csActive = !csS2_q;
  assign sclkRise = csActive && sclkS2_q && !sclkS3_q;
  assign sclkFall = csActive && !sclkS2_q && sclkS3_q;
  assign byteDone = sclkRise && (bitCnt_q == `RDFP_LAST_BIT);
  assign firstBit = sclkRise && (phase_q == PH_HEADER) && (bitCnt_q == 3'h0);
  assign errFlag = rxOverflow || txUnderflow;
  // the direction bit arrives first, so the fill level follows it at once
  assign fillSel = mosiS2_q ? rxCountStatus : txCountStatus;
  assign rxPopReq = sclkRise && (phase_q == PH_DATA) && isRead_q && (bitCnt_q == 3'h0);
  assign txPushReq = byteDone && (phase_q == PH_DATA) && !isRead_q;
  assign txPushData = {shiftIn_q[6:0], mosiS2_q};
  assign spiMiso = shiftOut_q[7];
  assign spiMisoOe = phase_q != PH_IDLE;

  // phase: idle until select, header byte, then data bytes until release
  always_comb
  begin
    phase_d = phase_q;
    unique case (phase_q)
      PH_IDLE:
        if (csActive)
          phase_d = PH_HEADER;
      PH_HEADER:
        if (!csActive)
          phase_d = PH_IDLE;
        else if (byteDone)
          phase_d = PH_DATA;
      PH_DATA:
        if (!csActive)
          phase_d = PH_IDLE;
      default:
        phase_d = PH_IDLE;
    endcase
  end

  assign bitCnt_d = !csActive ? 3'h0 : (sclkRise ? bitCnt_q + 3'h1 : bitCnt_q);
  assign isRead_d = firstBit ? mosiS2_q : isRead_q;
  assign shiftIn_d = sclkRise ? txPushData : shiftIn_q;
  // reads fetch on every byte boundary, header included
  assign loadPending_d = !csActive ? 1'b0 : (byteDone && isRead_q) ? 1'b1 :
                         ((sclkFall && loadPending_q) ? 1'b0 : loadPending_q);
  // status msb is the fault flag, the rest is the fill level
  assign shiftOut_d = (phase_q == PH_IDLE && csActive) ? {errFlag, 7'h00} :
                      firstBit ? {shiftOut_q[7], fillSel} :
                      (sclkFall && loadPending_q) ? rxOutData :
                      sclkFall ? {shiftOut_q[6:0], 1'b0} : shiftOut_q;

  // access engine registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      phase_q <= PH_IDLE;
      bitCnt_q <= 3'h0;
      isRead_q <= 1'b0;
      shiftIn_q <= '0;
      shiftOut_q <= '0;
      loadPending_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      bitCnt_q <= bitCnt_d;
      isRead_q <= isRead_d;
      shiftIn_q <= shiftIn_d;
      shiftOut_q <= shiftOut_d;
      loadPending_q <= loadPending_d;
    end
  end

  // ----------------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------------
  // small staging buffer absorbs modem bursts while the host reads
  rdfp_fifo #(.WIDTH(`RDFP_DATA_W), .DEPTH(`RDFP_STAGE_DEPTH), .DUP_HAZARD(0)) u_stage (
    .clk(clk),
    .rstn(rstn),
    .flush(rxFlush),
    .inValid(modemRxValid && modemRxReady), // a refused byte must not touch the head
    .inReady(stageReady),
    .inData(modemRxData),
    .outValid(stageValid),
    .outReady(rxInReady),
    .outData(stageData),
    .fillCount()
  );

  // receive fifo keeps the pointer slip on a simultaneous last read
  rdfp_fifo #(
    .WIDTH(`RDFP_DATA_W),
    .DEPTH(`RDFP_FIFO_DEPTH),
    .DUP_HAZARD(1)
  ) u_rx (
    .clk(clk),
    .rstn(rstn),
    .flush(rxFlush),
    .inValid(stageMove),
    .inReady(rxInReady),
    .inData(stageData),
    .outValid(rxOutValid),
    .outReady(rxPopReq),
    .outData(rxOutData),
    .fillCount(rxCountStatus)
  );

  // transmit fifo takes every host byte; overfilling corrupts the head
  rdfp_fifo #(.WIDTH(`RDFP_DATA_W), .DEPTH(`RDFP_FIFO_DEPTH), .DUP_HAZARD(0)) u_tx (
    .clk(clk),
    .rstn(rstn),
    .flush(txFlush),
    .inValid(txPushReq),
    .inReady(txInReady),
    .inData(txPushData),
    .outValid(modemTxValid),
    .outReady(modemTxPop),
    .outData(modemTxData),
    .fillCount(txCountStatus)
  );

  // ----------------------------------------------------------------------
  // sticky faults and threshold pin
  // ----------------------------------------------------------------------
  logic rxOvf_q; // receive overflow seen
  logic txUnf_q; // transmit underflow seen
  logic rxHit; // receive fill at or above threshold
  logic txHit; // transmit fill at or above threshold
  logic pinNext; // selected signal for the pin
  logic pin_q; // registered pin

  assign rxHit = rxCountStatus >= rxThreshold(thresholdConfig);
  assign txHit = txCountStatus >= txThreshold(thresholdConfig);
  assign pinNext = (outputPinSelect == `RDFP_SEL_RX_THR) ? rxHit :
                   (outputPinSelect == `RDFP_SEL_TX_THR) ? txHit : 1'b0;
  assign rxOverflow = rxOvf_q;
  assign txUnderflow = txUnf_q;
  assign generalOutputPin = pin_q;

  // a new fault in the flush cycle still sets the flag
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rxOvf_q <= 1'b0;
      txUnf_q <= 1'b0;
      pin_q <= 1'b0;
    end
    else
    begin
      rxOvf_q <= ovfEvent || (rxOvf_q && !rxFlush);
      txUnf_q <= unfEvent || (txUnf_q && !txFlush);
      pin_q <= pinNext;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_pin_rx;
    @(posedge clk) disable iff (!rstn)
    (outputPinSelect == `RDFP_SEL_RX_THR) |=>
      (generalOutputPin == ($past(rxCountStatus) >= rxThreshold($past(thresholdConfig))));
  endproperty
  a_pin_rx: assert property (p_pin_rx) else $error("rx threshold pin wrong");
  property p_pin_tx;
    @(posedge clk) disable iff (!rstn)
    (outputPinSelect == `RDFP_SEL_TX_THR) |=>
      (generalOutputPin == ($past(txCountStatus) >= txThreshold($past(thresholdConfig))));
  endproperty
  a_pin_tx: assert property (p_pin_tx) else $error("tx threshold pin wrong");
  property p_pin_off;
    @(posedge clk) disable iff (!rstn)
    (outputPinSelect != `RDFP_SEL_RX_THR && outputPinSelect != `RDFP_SEL_TX_THR)
      |=> !generalOutputPin;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin high on other code");
  property p_ovf_set;
    @(posedge clk) disable iff (!rstn)
    (modemRxValid && !modemRxReady) |=> rxOverflow;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");
  property p_unf_set;
    @(posedge clk) disable iff (!rstn)
    (modemTxPop && !modemTxValid) |=> txUnderflow;
  endproperty
  a_unf_set: assert property (p_unf_set) else $error("underflow not flagged");
  property p_ovf_hold;
    @(posedge clk) disable iff (!rstn)
    (rxOverflow && !rxFlush) |=> rxOverflow;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");
  property p_flush_clear;
    @(posedge clk) disable iff (!rstn)
    (txFlush && !unfEvent) |=> !txUnderflow && (txCountStatus == 7'h00);
  endproperty
  a_flush_clear: assert property (p_flush_clear) else $error("flush left tx state");

  property p_header_status;
    @(posedge clk) disable iff (!rstn)
    firstBit |=> (shiftOut_q[6:0] ==
      ($past(mosiS2_q) ? $past(rxCountStatus) : $past(txCountStatus)));
  endproperty
  a_header_status: assert property (p_header_status) else $error("status fill wrong");

  property p_tx_write;
    @(posedge clk) disable iff (!rstn)
    (txPushReq && txInReady && !modemTxPop && !txFlush) |=>
      (txCountStatus == $past(txCountStatus) + 7'h01);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("host write not stored");

  c_rx_ovf: cover property (@(posedge clk) disable iff (!rstn) ovfEvent);
  c_tx_unf: cover property (@(posedge clk) disable iff (!rstn) unfEvent);
  c_host_read: cover property (@(posedge clk) disable iff (!rstn) rxPopReq && rxOutValid);
  c_pin_high: cover property (@(posedge clk) disable iff (!rstn) generalOutputPin);

endmodule

// ==== tb/rdfp_spi_host.sv ====
`timescale 1ns/10ps

module rdfp_spi_host (
  // serial pins toward the device
  output logic csN,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  // --------------------
  // idle levels
  // --------------------
  // serial clock stands low outside frames, device deselected
  initial
  begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // odd offset keeps the link out of phase with the core clock
  task automatic open_frame();
    #37 csN = 1'b0;
    #300;
  endtask

  // one byte, msb first, sampled on the rise as the device expects
  task automatic shift(input logic [7:0] txb, output logic [7:0] rxb);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = txb[i];
      #200 sclk = 1'b1;
      rxb[i] = miso;
      #200 sclk = 1'b0;
    end
  endtask

  // released data line must not keep looking valid
  task automatic close_frame();
    #200 csN = 1'b1;
    mosi = ~mosi;
    #400;
  endtask
endmodule

// ==== tb/radio_data_fifo_pair_tb_top.sv ====
`timescale 1ns/10ps

module radio_data_fifo_pair_tb_top;
  import rdfp_pkg::*;

  // --------------------
  // signals and model
  // --------------------
  logic clk;
  logic rstn;
  logic spiCsN, spiSclk, spiMosi, spiMiso;
  logic spiMisoOe, misoLine; // enable from the design, line as the host sees it
  logic modemRxValid, modemRxReady, modemTxPop, modemTxValid;
  rdfp_byte_t modemRxData, modemTxData;
  logic rxFlush, txFlush, rxOverflow, txUnderflow, generalOutputPin;
  rdfp_thr_t thresholdConfig;
  rdfp_sel_t outputPinSelect;
  rdfp_count_t rxCountStatus, txCountStatus;
  // byte queues mirror what each fifo should hold
  logic [7:0] rxQ[$];
  logic [7:0] txQ[$];
  logic [7:0] st;
  logic [7:0] heldByte; // head byte expected twice
  int pollCount; // settled receive count
  integer seed = 32'h548cc7d7;
  int n_errors = 0;
  int n_compared = 0;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  rdfp_top rdfp_top_i (.clk(clk), .rstn(rstn), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .modemRxValid(modemRxValid),
    .modemRxReady(modemRxReady), .modemRxData(modemRxData), .modemTxPop(modemTxPop),
    .modemTxValid(modemTxValid), .modemTxData(modemTxData), .rxFlush(rxFlush),
    .txFlush(txFlush), .thresholdConfig(thresholdConfig), .outputPinSelect(outputPinSelect),
    .rxCountStatus(rxCountStatus), .txCountStatus(txCountStatus), .rxOverflow(rxOverflow),
    .txUnderflow(txUnderflow), .generalOutputPin(generalOutputPin));

  // a deselected line reads inverted, so a late or missing enable shows up
  assign misoLine = spiMisoOe ? spiMiso : !spiMiso;
  rdfp_spi_host rdfp_spi_host_i (.csN(spiCsN), .sclk(spiSclk), .mosi(spiMosi),
    .miso(misoLine));

  // --------------------
  // compare and report
  // --------------------
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: value %h, model %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: flag %b, model %b", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------
  // drivers
  // --------------------
  // back to back bytes; stops at the first refused byte
  task automatic push_rx(input int n);
    int k;
    logic rdy;
    k = 0;
    @(posedge clk);
    modemRxData <= 8'($random(seed));
    modemRxValid <= 1'b1;
    while (k < n)
    begin
      @(negedge clk) rdy = modemRxReady;
      @(posedge clk);
      if (!rdy)
        break;
      rxQ.push_back(modemRxData);
      modemRxData <= 8'($random(seed));
      k++;
    end
    modemRxValid <= 1'b0;
  endtask

  // the last pop may hit an empty fifo on purpose
  task automatic pop_tx(input int n);
    for (int i = 0; i < n; i++)
    begin
      repeat (2) @(negedge clk);
      chk_flag(modemTxValid, txQ.size() > 0);
      if (txQ.size() > 0)
        chk_data(modemTxData, txQ.pop_front());
      @(posedge clk) modemTxPop <= 1'b1;
      @(posedge clk) modemTxPop <= 1'b0;
    end
  endtask

  // read access: header then n data bytes, status byte returned
  task automatic spi_read(input int n, output logic [7:0] stat);
    logic [7:0] r;
    rdfp_spi_host_i.open_frame();
    rdfp_spi_host_i.shift(8'h80 | 8'($random(seed)), stat);
    for (int i = 0; i < n; i++)
    begin
      rdfp_spi_host_i.shift(8'($random(seed)), r);
      chk_data(r, rxQ.pop_front());
    end
    rdfp_spi_host_i.close_frame();
  endtask

  task automatic flush(input logic rx);
    @(posedge clk);
    rxFlush <= rx;
    txFlush <= !rx;
    @(posedge clk);
    rxFlush <= 1'b0;
    txFlush <= 1'b0;
    repeat (2) @(negedge clk);
    if (rx)
      rxQ.delete();
    else
      txQ.delete();
  endtask

  // every threshold setting under pin codes 0, 1 and 2, pin is registered
  task automatic chk_thr(input int rxn, input int txn);
    for (int n = 0; n < 16; n++)
      for (int s = 0; s < 3; s++)
      begin
        @(posedge clk);
        thresholdConfig <= 4'(n);
        outputPinSelect <= 6'(s);
        @(posedge clk);
        @(negedge clk);
        chk_flag(generalOutputPin, s == 0 ? rxn >= 4 * (n + 1) : s == 2 && txn >= 61 - 4 * n);
      end
  endtask

  // --------------------
  // main sequence
  // --------------------
  initial
  begin
    rstn = 1'b0;
    modemRxValid = 1'b0;
    modemRxData = 8'h00;
    modemTxPop = 1'b0;
    rxFlush = 1'b0;
    txFlush = 1'b0;
    thresholdConfig = 4'h0;
    outputPinSelect = 6'h00;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk_data({1'b0, rxCountStatus}, 8'h00);
    chk_flag(rxOverflow | txUnderflow | modemTxValid | generalOutputPin | spiMisoOe, 1'b0);
    // write access of nine bytes, status shows the empty transmit side
    rdfp_spi_host_i.open_frame();
    rdfp_spi_host_i.shift(8'h7f & 8'($random(seed)), st);
    chk_data(st, 8'h00);
    repeat (9)
    begin
      txQ.push_back(8'($random(seed)));
      rdfp_spi_host_i.shift(txQ[$], st);
    end
    rdfp_spi_host_i.close_frame();
    push_rx(56);
    repeat (4) @(negedge clk);
    chk_data({1'b0, txCountStatus}, 8'(txQ.size()));
    chk_data({1'b0, rxCountStatus}, 8'(rxQ.size()));
    chk_thr(56, 9);
    // packet complete, fifo not drained to empty
    spi_read(3, st);
    chk_data(st, 8'h38);
    chk_data({1'b0, rxCountStatus}, 8'(rxQ.size()));
    // poll until two equal counts, then leave one byte behind
    do
    begin
      pollCount = rxCountStatus;
      repeat (4) @(negedge clk);
    end
    while (pollCount != rxCountStatus);
    spi_read(pollCount - 1, st);
    chk_data(st, 8'(pollCount));
    // a modem byte lands in the cycle the host takes the last one
    heldByte = rxQ[0];
    fork
      spi_read(1, st);
      begin
        repeat (9) @(posedge spiSclk);
        push_rx(1);
      end
    join
    rxQ.push_front(heldByte);
    chk_data({1'b0, rxCountStatus}, 8'(rxQ.size()));
    pop_tx(10);
    repeat (2) @(negedge clk);
    chk_flag(txUnderflow, 1'b1);
    chk_data({1'b0, txCountStatus}, 8'h00);
    spi_read(0, st);
    chk_flag(st[7], 1'b1);
    chk_flag(txUnderflow, 1'b1);
    flush(1'b0);
    chk_flag(txUnderflow, 1'b0);
    // fill receive side past staging until a byte is refused
    flush(1'b1);
    push_rx(80);
    repeat (4) @(negedge clk);
    chk_flag(rxOverflow, 1'b1);
    chk_data({1'b0, rxCountStatus}, 8'h40);
    chk_thr(64, 0);
    chk_flag(rxOverflow, 1'b1);
    flush(1'b1);
    chk_flag(rxOverflow, 1'b0);
    chk_data({1'b0, rxCountStatus}, 8'h00);
    close_out();
  end

  // cuts a hang short well beyond the expected run
  initial
  begin
    #1000000;
    n_errors++;
    close_out();
  end
endmodule
